// ===== src/lrr_pkg.sv
/*
 * Shared constants, types and helpers for the light result readout block.
 * Assumes a single device with a 7-bit serial target address and 8-bit registers.
 */
package lrr_pkg;

    // Serial target address, without the direction bit.
    localparam logic [6:0] TARGET_ADDR = 7'h29;

    // Register offsets.
    localparam logic [7:0] OFS_DEVICE_IDENT = 8'h86;
    localparam logic [7:0] OFS_MAKER_IDENT = 8'h87;
    localparam logic [7:0] OFS_CH1_COUNT_LOW = 8'h88;
    localparam logic [7:0] OFS_CH1_COUNT_HIGH = 8'h89;
    localparam logic [7:0] OFS_CH0_COUNT_LOW = 8'h8a;
    localparam logic [7:0] OFS_CH0_COUNT_HIGH = 8'h8b;
    localparam logic [7:0] OFS_RESULT_FLAGS = 8'h8c;

    // Field positions of the result flags register.
    localparam int FLAG_INVALID_BIT = 7;
    localparam int FLAG_GAIN_MSB = 6;
    localparam int FLAG_GAIN_LSB = 4;
    localparam int FLAG_FRESH_BIT = 2;

    // Identification defaults; these values are arbitrary.
    localparam logic [3:0] DEF_PART_CODE = 4'h3;
    localparam logic [3:0] DEF_REV_CODE = 4'h1;
    localparam logic [7:0] DEF_MAKER_CODE = 8'h5a;

    // Reset values and answer to an unmapped offset.
    localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // Bit counting within one serial byte.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // One finished measurement as delivered by the converter.
    typedef struct packed {
        logic invalid;
        logic [2:0] gain;
        logic [15:0] ch1;
        logic [15:0] ch0;
    } lrr_meas_t;

    localparam lrr_meas_t MEAS_RESET = '0;

    typedef enum logic [3:0] {
        L_IDLE,
        L_ADDR,
        L_ADDR_ACK,
        L_REG,
        L_REG_ACK,
        L_WDATA,
        L_WDATA_ACK,
        L_RDATA,
        L_RDATA_ACK
    } lrr_link_state_t;

    function automatic logic is_data(input logic [7:0] ofs);
        return (ofs >= OFS_CH1_COUNT_LOW) && (ofs <= OFS_CH0_COUNT_HIGH);
    endfunction

endpackage

// ===== src/lrr_sync.sv
/*
 * Two-stage synchroniser for a group of independent level or toggle bits.
 * Assumes each bit changes at most once per few destination clock periods.
 */
`timescale 1ns/1ps
module lrr_sync #(
    parameter int WIDTH = 1,
    // Level held through reset, chosen to match the idle level of the source.
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Levels from another domain
    input wire logic [WIDTH-1:0] din,
    // Synchronised levels
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    // Only the second stage reads the first one, to keep metastability contained.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= RESET_VALUE;
            dout <= RESET_VALUE;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule

// ===== src/lrr_readout.sv
/*
 * Result readout of a two-channel light sensor: serial target on the link clock,
 * result registers with freeze and shadow storage on the system clock.
 * Assumes a free-running link clock much faster than the serial clock and a
 * one-cycle measurement strobe from logic on the system clock.
 */
`timescale 1ns/1ps
module lrr_readout #(
    parameter logic [3:0] PART_CODE = lrr_pkg::DEF_PART_CODE,
    parameter logic [3:0] REV_CODE = lrr_pkg::DEF_REV_CODE,
    parameter logic [7:0] MAKER_CODE = lrr_pkg::DEF_MAKER_CODE
) (
    // System clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Link clock
    input wire logic link_clk,
    // Measurement from the converter
    input wire logic meas_valid,
    input wire lrr_pkg::lrr_meas_t meas,
    // Serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);

    // Link domain state.
    lrr_pkg::lrr_link_state_t state;
    logic [2:0] pin_s;
    logic scl_s;
    logic sda_s;
    logic rsp_tgl_s;
    logic scl_q;
    logic sda_q;
    logic rsp_seen;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic reading;
    logic mack;
    logic [7:0] fetch_addr;
    logic [7:0] done_addr;
    logic [7:0] rsp_latch;
    logic req_tgl;
    logic done_tgl;
    logic stop_tgl;

    // System domain state.
    logic [2:0] ev_s;
    logic [2:0] ev_q;
    logic [7:0] rsp_data;
    logic rsp_tgl;
    logic frozen;
    logic pending;
    logic fresh;
    lrr_pkg::lrr_meas_t shadow;
    lrr_pkg::lrr_meas_t visible;

    // Pins come out of reset at their idle high level, so no false edge follows reset.
    lrr_sync #(.WIDTH(3), .RESET_VALUE(3'h6)) u_pin_sync (
        .clk(link_clk),
        .arst_n(arst_n),
        .din({scl_i, sda_i, rsp_tgl}),
        .dout(pin_s)
    );

    lrr_sync #(.WIDTH(3)) u_ev_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din({req_tgl, done_tgl, stop_tgl}),
        .dout(ev_s)
    );

    assign scl_s = pin_s[2];
    assign sda_s = pin_s[1];
    assign rsp_tgl_s = pin_s[0];

    // Bus conditions, seen on the synchronised pins.
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
    wire byte_in = scl_fall && (cnt == lrr_pkg::BYTE_BITS);
    wire addr_hit = (shift[7:1] == lrr_pkg::TARGET_ADDR);
    wire rsp_ev = rsp_tgl_s ^ rsp_seen;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rsp_seen <= 1'b0;
            rsp_latch <= lrr_pkg::UNMAPPED_BYTE;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            rsp_seen <= rsp_tgl_s;
            if (rsp_ev) begin
                rsp_latch <= rsp_data;
            end
        end
    end

    // The pin only ever pulls low; the enable alone decides the wire level.
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // Serial target. No clock stretching: the next byte is fetched at the
    // acknowledge rising edge, leaving half a bit time for the crossing.
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= lrr_pkg::L_IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= lrr_pkg::PTR_RESET;
            reading <= 1'b0;
            mack <= 1'b0;
            fetch_addr <= lrr_pkg::PTR_RESET;
            done_addr <= lrr_pkg::PTR_RESET;
            req_tgl <= 1'b0;
            done_tgl <= 1'b0;
            stop_tgl <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (stop_c) begin
            state <= lrr_pkg::L_IDLE;
            sda_oe_n <= 1'b1;
            stop_tgl <= ~stop_tgl;
        end else if (start_c) begin
            state <= lrr_pkg::L_ADDR;
            cnt <= 4'h0;
            sda_oe_n <= 1'b1;
        end else begin
            case (state)
                lrr_pkg::L_ADDR, lrr_pkg::L_REG, lrr_pkg::L_WDATA: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_s};
                        cnt <= cnt + 4'h1;
                    end else if (byte_in) begin
                        if (state == lrr_pkg::L_ADDR) begin
                            if (addr_hit) begin
                                sda_oe_n <= 1'b0;
                                state <= lrr_pkg::L_ADDR_ACK;
                                reading <= shift[0];
                                if (shift[0]) begin
                                    fetch_addr <= ptr;
                                    req_tgl <= ~req_tgl;
                                end
                            end else begin
                                state <= lrr_pkg::L_IDLE;
                            end
                        end else if (state == lrr_pkg::L_REG) begin
                            ptr <= shift;
                            sda_oe_n <= 1'b0;
                            state <= lrr_pkg::L_REG_ACK;
                        end else begin
                            ptr <= ptr + 8'h01;
                            sda_oe_n <= 1'b0;
                            state <= lrr_pkg::L_WDATA_ACK;
                        end
                    end
                end
                lrr_pkg::L_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt <= 4'h0;
                        if (reading) begin
                            state <= lrr_pkg::L_RDATA;
                            shift <= rsp_latch;
                            sda_oe_n <= rsp_latch[7];
                        end else begin
                            state <= lrr_pkg::L_REG;
                            sda_oe_n <= 1'b1;
                        end
                    end
                end
                lrr_pkg::L_REG_ACK, lrr_pkg::L_WDATA_ACK: begin
                    if (scl_fall) begin
                        cnt <= 4'h0;
                        sda_oe_n <= 1'b1;
                        state <= lrr_pkg::L_WDATA;
                    end
                end
                lrr_pkg::L_RDATA: begin
                    if (scl_fall) begin
                        if (cnt == lrr_pkg::LAST_BIT) begin
                            sda_oe_n <= 1'b1;
                            state <= lrr_pkg::L_RDATA_ACK;
                        end else begin
                            cnt <= cnt + 4'h1;
                            shift <= {shift[6:0], 1'b0};
                            sda_oe_n <= shift[6];
                        end
                    end
                end
                lrr_pkg::L_RDATA_ACK: begin
                    if (scl_rise) begin
                        done_addr <= ptr;
                        done_tgl <= ~done_tgl;
                        ptr <= ptr + 8'h01;
                        mack <= ~sda_s;
                        if (!sda_s) begin
                            fetch_addr <= ptr + 8'h01;
                            req_tgl <= ~req_tgl;
                        end
                    end else if (scl_fall) begin
                        cnt <= 4'h0;
                        if (mack) begin
                            state <= lrr_pkg::L_RDATA;
                            shift <= rsp_latch;
                            sda_oe_n <= rsp_latch[7];
                        end else begin
                            state <= lrr_pkg::L_IDLE;
                        end
                    end
                end
                default: begin
                    state <= lrr_pkg::L_IDLE;
                end
            endcase
        end
    end

    // System domain: event decode. Addresses are held by the link side until
    // its next event, so they are stable when the synchronised toggle arrives.
    wire req_ev = ev_s[2] ^ ev_q[2];
    wire done_ev = ev_s[1] ^ ev_q[1];
    wire stop_ev = ev_s[0] ^ ev_q[0];
    wire data_fetch = req_ev & lrr_pkg::is_data(fetch_addr);
    wire data_done = done_ev & lrr_pkg::is_data(done_addr);
    wire freeze_end = stop_ev | (done_ev & (done_addr == lrr_pkg::OFS_CH0_COUNT_HIGH));
    wire block = frozen | data_fetch;
    wire live_update = meas_valid & ~block;
    wire shadow_update = pending & ~block & ~meas_valid;
    wire vis_update = live_update | shadow_update;

    wire [7:0] flags_byte = {visible.invalid, visible.gain, 1'b0, fresh, 2'b00};
    wire [7:0] read_byte =
        (fetch_addr == lrr_pkg::OFS_DEVICE_IDENT) ? {PART_CODE, REV_CODE} :
        (fetch_addr == lrr_pkg::OFS_MAKER_IDENT) ? MAKER_CODE :
        (fetch_addr == lrr_pkg::OFS_CH1_COUNT_LOW) ? visible.ch1[7:0] :
        (fetch_addr == lrr_pkg::OFS_CH1_COUNT_HIGH) ? visible.ch1[15:8] :
        (fetch_addr == lrr_pkg::OFS_CH0_COUNT_LOW) ? visible.ch0[7:0] :
        (fetch_addr == lrr_pkg::OFS_CH0_COUNT_HIGH) ? visible.ch0[15:8] :
        (fetch_addr == lrr_pkg::OFS_RESULT_FLAGS) ? flags_byte :
        lrr_pkg::UNMAPPED_BYTE;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ev_q <= 3'h0;
            rsp_data <= lrr_pkg::UNMAPPED_BYTE;
            rsp_tgl <= 1'b0;
        end else begin
            ev_q <= ev_s;
            if (req_ev) begin
                rsp_data <= read_byte;
                rsp_tgl <= ~rsp_tgl;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frozen <= 1'b0;
        end else if (data_fetch) begin
            frozen <= 1'b1;
        end else if (freeze_end) begin
            frozen <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending <= 1'b0;
            shadow <= lrr_pkg::MEAS_RESET;
        end else if (meas_valid & block) begin
            pending <= 1'b1;
            shadow <= meas;
        end else if (!block) begin
            pending <= 1'b0;
        end
    end

    // data bytes reset to zero, refresh per measurement when not frozen, else from shadow once the freeze ends
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            visible <= lrr_pkg::MEAS_RESET;
        end else if (live_update) begin
            visible <= meas;
        end else if (shadow_update) begin
            visible <= shadow;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fresh <= 1'b0;
        end else if (vis_update) begin
            fresh <= 1'b1;
        end else if (data_done) begin
            fresh <= 1'b0;
        end
    end

    fresh_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        vis_update |=> fresh) else $error("fresh flag not set on update");
    fresh_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
        (data_done && !vis_update) |=> !fresh) else $error("fresh flag not cleared");
    freeze_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (frozen && !freeze_end) |=> frozen && $stable(visible))
        else $error("data bytes moved while frozen");
    park_a: assert property (@(posedge clk) disable iff (!arst_n)
        (meas_valid && block) |=> pending && (shadow == $past(meas)) && $stable(visible))
        else $error("frozen result not parked");
    shadow_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
        (pending && !block && !meas_valid) |=> !pending && (visible == $past(shadow)))
        else $error("parked result not copied");
    unfreeze_a: assert property (@(posedge clk) disable iff (!arst_n)
        (freeze_end && !data_fetch) |=> !frozen) else $error("freeze did not end");
    ro_data_a: assert property (@(posedge clk) disable iff (!arst_n)
        !vis_update |=> $stable(visible)) else $error("data bytes changed without result");
    ch1_low_a: assert property (@(posedge clk) disable iff (!arst_n)
        (req_ev && fetch_addr == lrr_pkg::OFS_CH1_COUNT_LOW) |=> rsp_data == visible.ch1[7:0])
        else $error("channel-1 low byte wrong");
    ch0_high_a: assert property (@(posedge clk) disable iff (!arst_n)
        (req_ev && fetch_addr == lrr_pkg::OFS_CH0_COUNT_HIGH) |=> rsp_data == visible.ch0[15:8])
        else $error("channel-0 high byte wrong");
    flags_map_a: assert property (@(posedge clk) disable iff (!arst_n)
        (req_ev && fetch_addr == lrr_pkg::OFS_RESULT_FLAGS) |=> (rsp_data[3] == 1'b0)
        && (rsp_data[1:0] == 2'b00) && (rsp_data[2] == $past(fresh))
        && (rsp_data[7] == $past(visible.invalid)) && (rsp_data[6:4] == $past(visible.gain)))
        else $error("flags byte layout wrong");
    part_ident_a: assert property (@(posedge clk) disable iff (!arst_n)
        (req_ev && fetch_addr == lrr_pkg::OFS_DEVICE_IDENT) |=> rsp_data == {PART_CODE, REV_CODE})
        else $error("identification byte wrong");
    maker_ident_a: assert property (@(posedge clk) disable iff (!arst_n)
        (req_ev && fetch_addr == lrr_pkg::OFS_MAKER_IDENT) |=> rsp_data == MAKER_CODE)
        else $error("maker byte wrong");
    addr_ack_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        (state == lrr_pkg::L_ADDR && byte_in && addr_hit && !start_c && !stop_c)
        |=> !sda_oe_n && state == lrr_pkg::L_ADDR_ACK) else $error("address not acknowledged");

endmodule

// ===== verif/lrr_host_model.sv
/*
 * Behavioural serial bus master that stands on the host side of the readout block.
 * Assumes a pull-up on the data line, resolved outside, and one caller at a time.
 */
`timescale 1ns/1ps
module lrr_host_model (
    // Bus wires driven by the master
    output logic scl,
    output logic sda_oe_n,
    // Resolved data line level
    input wire logic sda
);
    // The long high time leaves room for the device's synchroniser lag.
    localparam int QTR = 500;
    localparam int HIGH = 1200;

    initial begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end

    // Data only changes while the clock is low.
    task automatic put_bit(input logic b, output logic r);
        sda_oe_n = b;
        #QTR;
        scl = 1'b1;
        #HIGH;
        r = sda;
        scl = 1'b0;
        #QTR;
    endtask

    // Works from idle and as a repeated start from a low clock.
    task automatic start();
        sda_oe_n = 1'b1;
        #QTR;
        scl = 1'b1;
        #QTR;
        sda_oe_n = 1'b0;
        #QTR;
        scl = 1'b0;
        #QTR;
    endtask

    task automatic stop();
        sda_oe_n = 1'b0;
        #QTR;
        scl = 1'b1;
        #QTR;
        sda_oe_n = 1'b1;
        #QTR;
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], r);
        end
        put_bit(1'b1, ack);
    endtask

    // A high acknowledge bit on the last byte ends the read burst.
    task automatic get_byte(output logic [7:0] b, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            b[i] = r;
        end
        put_bit(last, r);
    endtask
endmodule

// ===== verif/testbench.sv
/*
 * Self-checking bench for the light result readout block over its serial port.
 * Assumes the block's default identity parameters and a host model on the bus.
 */
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic arst_n;
    logic link_clk;
    logic meas_valid;
    lrr_pkg::lrr_meas_t meas;
    logic scl;
    logic host_oe_n;
    logic sda_o;
    logic sda_oe_n;
    wire logic sda_line;
    logic [7:0] got [0:7];
    int bad_count;
    int check_count;

    assign sda_line = (sda_oe_n | sda_o) & host_oe_n;

    lrr_readout i_lrr_readout (
        .clk(clk),
        .arst_n(arst_n),
        .link_clk(link_clk),
        .meas_valid(meas_valid),
        .meas(meas),
        .scl_i(scl),
        .sda_i(sda_line),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n)
    );

    lrr_host_model i_lrr_host_model (
        .scl(scl),
        .sda_oe_n(host_oe_n),
        .sda(sda_line)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chkb(input int n, input logic [63:0] e);
        for (int i = 0; i < n; i++) begin
            chk(got[i], e[63-8*i -: 8]);
        end
    endtask

    task automatic pulse(input lrr_pkg::lrr_meas_t m);
        @(negedge clk);
        meas = m;
        meas_valid = 1'b1;
        @(negedge clk);
        meas_valid = 1'b0;
    endtask

    // Sets the pointer, then reads n bytes; a measurement goes in after byte inj.
    task automatic rd(input logic [7:0] ptr, input int n, input int inj,
                      input lrr_pkg::lrr_meas_t m);
        logic a;
        i_lrr_host_model.start();
        i_lrr_host_model.put_byte({lrr_pkg::TARGET_ADDR, 1'b0}, a);
        chk({7'h00, a}, 8'h00);
        i_lrr_host_model.put_byte(ptr, a);
        i_lrr_host_model.start();
        i_lrr_host_model.put_byte({lrr_pkg::TARGET_ADDR, 1'b1}, a);
        chk({7'h00, a}, 8'h00);
        for (int i = 0; i < n; i++) begin
            i_lrr_host_model.get_byte(got[i], i == n - 1);
            if (i + 1 == inj) begin
                pulse(m);
            end
        end
        i_lrr_host_model.stop();
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
        logic a;
        i_lrr_host_model.start();
        i_lrr_host_model.put_byte({lrr_pkg::TARGET_ADDR, 1'b0}, a);
        i_lrr_host_model.put_byte(ptr, a);
        i_lrr_host_model.put_byte(v, a);
        chk({7'h00, a}, 8'h00);
        i_lrr_host_model.stop();
    endtask

    initial begin
        #3_500_000;
        bad_count++;
        final_report();
    end

    initial begin
        logic a;
        logic [2:0] gcode;
        arst_n = 1'b0;
        meas_valid = 1'b0;
        meas = '0;
        bad_count = 0;
        check_count = 0;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (10) @(negedge clk);
        rd(8'h86, 8, 0, '0);
        chkb(8, {lrr_pkg::DEF_PART_CODE, lrr_pkg::DEF_REV_CODE, lrr_pkg::DEF_MAKER_CODE,
                 40'h00_0000_0000, lrr_pkg::UNMAPPED_BYTE});
        for (int g = 0; g < 8; g++) begin
            gcode = 3'(g);
            pulse({gcode[0], gcode, 32'h0000_0000});
            rd(8'h8c, 1, 0, '0);
            chk(got[0], {gcode[0], gcode, 4'h4});
        end
        pulse({1'b1, 3'h6, 16'h1234, 16'habcd});
        rd(8'h88, 4, 1, {1'b0, 3'h1, 16'h5566, 16'h7788});
        chkb(4, 64'h3412_cdab_0000_0000);
        rd(8'h8c, 1, 0, '0);
        chk(got[0], 8'h14);
        rd(8'h88, 4, 0, '0);
        chkb(4, 64'h6655_8877_0000_0000);
        rd(8'h8c, 1, 0, '0);
        chk(got[0], 8'h10);
        rd(8'h88, 1, 1, {1'b1, 3'h3, 16'hc1c2, 16'hc3c4});
        chk(got[0], 8'h66);
        rd(8'h88, 4, 0, '0);
        chkb(4, 64'hc2c1_c4c3_0000_0000);
        wr(8'h88, 8'hff);
        wr(8'h8c, 8'hff);
        rd(8'h8c, 1, 0, '0);
        chk(got[0], 8'hb0);
        rd(8'h88, 4, 0, '0);
        chkb(4, 64'hc2c1_c4c3_0000_0000);
        i_lrr_host_model.start();
        i_lrr_host_model.put_byte({lrr_pkg::TARGET_ADDR ^ 7'h01, 1'b0}, a);
        chk({7'h00, a}, 8'h01);
        i_lrr_host_model.stop();
        final_report();
    end
endmodule
